// *** bench/bsc_host_model.sv ***
// register-bus master model standing in for the application processor
`timescale 1ns/1ps
`default_nettype none
module bsc_host_model (
    input wire logic mclk,
    output logic [7:0] regAddr,
    output logic [31:0] regWdata,
    output logic regWr,
    output logic regRd,
    input wire logic [31:0] regRdata
);
    // bus idles with both strobes low from time zero
    initial
    begin
        regAddr = 8'h00;
        regWdata = 32'h00000000;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // one-cycle write; a gap cycle follows so a strobe is never set twice in a step
    // recodes assume the stage was already forced to fixed-frequency mode (no pin here)
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    // one-cycle read; data stands only in the cycle after the strobe
    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask : rdr
endmodule : bsc_host_model
`default_nettype wire

// *** bench/buck_setpoint_control_bench.sv ***
// self-checking bench for the buck set-point control top
`timescale 1ns/1ps
`default_nettype none
module buck_setpoint_control_bench;
    import bsc_pkg::*;
    localparam int BASE = 5;
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic clkEn = 1'b1;
    logic [4:0] ocPin = 5'h00;
    logic standby = 1'b0;
    logic [1:0] phasePin = 2'h0;
    logic [1:0] strap = 2'h0;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, rdv;
    logic regWr, regRd, irq;
    logic [15:0] v1, v2, v3, v4, v5;
    logic [1:0] phMode;
    logic [15:0] strapV [3] = '{V_LOWR_BASE, V_2V5, V_3V15};
    logic [15:0] hiV [3] = '{V_2V5, V_3V15, V_3V3};
    logic [7:0] ra [6] = '{REG_MASK, REG_SPEED, REG_B1_NORM, REG_B2_STBY, REG_STATUS, 8'h30};
    logic [31:0] rv [6] = '{32'h1f, 32'h5, 32'h20, 32'h10, 32'h0, 32'h0};
    int cs [4] = '{0, 1, 26, 31};
    int error_cnt = 0;
    int checks_done = 0;
    int n;
    logic [5:0] tgt, c1;
    // 4 ns clock
    always #2 mclk = ~mclk;
    bsc_top #(.DVS_BASE_CYC_P(BASE)) bsc_top_i (.mclk(mclk), .sys_rst(sysRst), .clkEn(clkEn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .overcurrentPin(ocPin), .standbyPin(standby),
        .buck4PhaseConfigPin(phasePin), .powerUpModeSelectPin(strap), .buck1Voltage(v1),
        .buck2Voltage(v2), .buck3Voltage(v3), .buck4Voltage(v4), .buck5Voltage(v5),
        .buck4PhaseMode(phMode), .shortCircuitProtectInterrupt(irq));
    bsc_host_model host (.mclk(mclk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata));
    ////////////////////////////////////////////////////////////
    // expected voltages in 100 uV units
    function automatic logic [15:0] f6(input logic [5:0] c);
        return V_FINE_BASE + 16'(c) * V_FINE_STEP;
    endfunction : f6
    function automatic logic [15:0] f5(input logic [15:0] base, input int c);
        return base + 16'(c) * V_COARSE_STEP;
    endfunction : f5
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // bounded wait for buck1 or buck2 to show v; cyc counts edges waited
    task automatic waitv(input int b, input logic [15:0] v, output int cyc);
        logic [15:0] s;
        cyc = 0;
        do
        begin
            @(posedge mclk);
            #1;
            cyc++;
            s = (b == 1) ? v1 : v2;
        end while (s !== v && cyc < 2000);
        if (s !== v)
        begin
            chk(s, v);
            conclude();
        end
    endtask : waitv
    task automatic rst(input logic [1:0] ph, input logic [1:0] st);
        @(posedge mclk);
        sysRst <= 1'b1;
        phasePin <= ph;
        strap <= st;
        repeat (6) @(posedge mclk);
        sysRst <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
    endtask : rst
    ////////////////////////////////////////////////////////////
    initial
    begin
        // strap capture per phase arrangement, then the exit from the high range
        for (int i = 0; i < 3; i++)
        begin
            rst(2'(i), 2'(i));
            chk(phMode, i);
            chk(v4, strapV[i]);
            if (i == 0)
            begin
                for (int k = 0; k < 6; k++)
                begin
                    host.rdr(ra[k], rdv);
                    chk(rdv, rv[k]);
                end
            end
            @(posedge mclk);
            phasePin <= 2'(i + 1);
            host.wr(REG_CFG, 32'h0);
            repeat (3) @(posedge mclk);
            host.rdr(REG_CFG, rdv);
            chk(rdv[1:0], i);
            chk(phMode, i);
            host.wr(REG_B4, 32'h04);
            repeat (2) @(posedge mclk);
            #1;
            chk(v4, (i == 0) ? f5(V_LOWR_BASE, 4) : V_2V5);
        end
        $display("test strap done");
        // fixed code tables of bucks three, four and five
        for (int k = 0; k < 4; k++)
        begin
            host.wr(REG_B3, cs[k]);
            host.wr(REG_B4, cs[k] % 32);
            host.wr(REG_B5, cs[k] % 32);
            repeat (2) @(posedge mclk);
            #1;
            chk(v3, f5(V_FINE_BASE, cs[k]));
            if (k < 3)
            begin
                chk(v4, f5(V_LOWR_BASE, cs[k]));
                chk(v5, f5(V_LOWR_BASE, cs[k]));
            end
        end
        for (int h = 1; h < 4; h++)
        begin
            host.wr(REG_B4, 32'(h << B4_HI_LSB));
            repeat (2) @(posedge mclk);
            #1;
            chk(v4, hiV[h - 1]);
        end
        host.wr(REG_B4, 32'h03);
        repeat (2) @(posedge mclk);
        #1;
        chk(v4, V_2V5);
        $display("test codes done");
        // fault flags: each buck alone, flag holds while the fault lasts
        for (int b = 0; b < 5; b++)
        begin
            @(posedge mclk);
            ocPin <= 5'(1 << b);
            repeat (4) @(posedge mclk);
            #1;
            chk(irq, 1);
            host.wr(REG_STATUS, 32'h1f);
            host.rdr(REG_STATUS, rdv);
            chk(rdv, 1 << b);
            @(posedge mclk);
            ocPin <= 5'h00;
            repeat (3) @(posedge mclk);
            host.wr(REG_STATUS, 1 << b);
            host.rdr(REG_STATUS, rdv);
            chk(rdv, 0);
            chk(irq, 0);
        end
        // a masked fault keeps its flag but holds the interrupt low
        host.wr(REG_MASK, 32'h1e);
        @(posedge mclk);
        ocPin <= 5'h01;
        repeat (4) @(posedge mclk);
        #1;
        chk(irq, 0);
        host.wr(REG_MASK, 32'h1f);
        repeat (2) @(posedge mclk);
        #1;
        chk(irq, 1);
        $display("test faults done");
        // stepping rate per speed code, alternating direction
        waitv(1, f6(6'h20), n);
        for (int s = 0; s < 4; s++)
        begin
            host.wr(REG_SPEED, 32'((s << SPEED2_LSB) | s));
            tgt = (s % 2 == 1) ? 6'h20 : 6'h24;
            c1 = (s % 2 == 1) ? 6'h23 : 6'h21;
            host.wr(REG_B1_NORM, 32'(tgt));
            waitv(1, f6(c1), n);
            waitv(1, f6((s % 2 == 1) ? 6'h22 : 6'h22), n);
            chk(n, BASE << s);
            waitv(1, f6(tgt), n);
        end
        $display("test rates done");
        // standby entry and exit on both bucks at the 8 us code; buck2 parks higher
        host.wr(REG_B2_STBY, 32'h18);
        host.wr(REG_SPEED, 32'ha);
        @(posedge mclk);
        standby <= 1'b1;
        waitv(1, f6(6'h1f), n);
        waitv(1, f6(6'h1e), n);
        chk(n, BASE << 2);
        // clock enable low freezes stepping and refuses register writes
        @(posedge mclk);
        clkEn <= 1'b0;
        host.wr(REG_B3, 32'h05);
        repeat (30) @(posedge mclk);
        #1;
        chk(v1, f6(6'h1e));
        @(posedge mclk);
        clkEn <= 1'b1;
        host.rdr(REG_B3, rdv);
        chk(rdv, 32'h1f);
        waitv(1, f6(6'h10), n);
        waitv(2, f6(6'h18), n);
        chk(v1, f6(6'h10));
        host.rdr(REG_DVS, rdv);
        chk(rdv, 32'h1810);
        @(posedge mclk);
        standby <= 1'b0;
        waitv(1, f6(6'h20), n);
        waitv(2, f6(6'h20), n);
        chk(v2, f6(6'h20));
        $display("test standby done");
        conclude();
    end
endmodule : buck_setpoint_control_bench
`default_nettype wire

// *** verilog/bsc_dvs_if.sv ***
// carrier between the control top and a voltage stepper
`timescale 1ns/1ps
`default_nettype none
interface bsc_dvs_if;
    logic ce;
    logic [bsc_pkg::NORM_W-1:0] target;
    logic [1:0] speed;
    logic [bsc_pkg::NORM_W-1:0] current;
    logic busy;
    modport ctl (output ce, target, speed, input current, busy);
    modport step (input ce, target, speed, output current, busy);
endinterface : bsc_dvs_if
`default_nettype wire

// *** verilog/bsc_dvs_stepper.sv ***
// stepper that walks a 6-bit set point toward its target one code at a time
`timescale 1ns/1ps
`default_nettype none
module bsc_dvs_stepper #(
    parameter int BASE_CYC = bsc_pkg::DVS_BASE_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    bsc_dvs_if.step dvs
);
    import bsc_pkg::*;

    typedef struct packed {
        logic [NORM_W-1:0] code;
        logic [CNT_W-1:0] cnt;
    } bsc_step_s;

    localparam logic [CNT_W-1:0] BASE = CNT_W'(BASE_CYC);

    bsc_step_s q;
    bsc_step_s d;
    logic [CNT_W-1:0] period;

    ////////////////////////////////////////////////////////////////////////////////
    // one code (12.5 mV) per period; period doubles with each speed code
    assign period = BASE << dvs.speed;
    always_comb
    begin
        d = q;
        if (q.code == dvs.target)
            d.cnt = '0;
        else if (q.cnt == period - 12'h001)
        begin
            // no jump: only a single code per period, toward the target
            d.cnt = '0;
            d.code = (dvs.target > q.code) ? q.code + 6'h01 : q.code - 6'h01;
        end
        else
            d.cnt = q.cnt + 12'h001;
    end

    // frozen while the clock enable is low
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            q.code <= NORM_RST;
            q.cnt <= '0;
        end
        else if (dvs.ce)
            q <= d;
    end

    assign dvs.current = q.code;
    assign dvs.busy = (q.code != dvs.target);

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_dvs_single_step: assert property (
        $changed(q.code) |-> (q.code == $past(q.code) + 6'h01) ||
                             (q.code == $past(q.code) - 6'h01))
        else $error("set point moved by more than one code");
    chk_dvs_step_period: assert property (
        $changed(q.code) |-> $past(q.cnt) == $past(period) - 12'h001)
        else $error("set point stepped before its period elapsed");
    chk_dvs_step_up: assert property (
        dvs.ce && q.code < dvs.target && q.cnt == period - 12'h001
        |=> q.code == $past(q.code) + 6'h01)
        else $error("stepper did not move up toward target");
endmodule : bsc_dvs_stepper
`default_nettype wire

// *** verilog/bsc_pkg.sv ***
// shared constants and types for the buck set-point control block
package bsc_pkg;
    // register byte offsets
    localparam logic [7:0] REG_B1_NORM = 8'h00;
    localparam logic [7:0] REG_B1_STBY = 8'h04;
    localparam logic [7:0] REG_B2_NORM = 8'h08;
    localparam logic [7:0] REG_B2_STBY = 8'h0c;
    localparam logic [7:0] REG_SPEED = 8'h10;
    localparam logic [7:0] REG_B3 = 8'h14;
    localparam logic [7:0] REG_B4 = 8'h18;
    localparam logic [7:0] REG_B5 = 8'h1c;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_MASK = 8'h24;
    localparam logic [7:0] REG_CFG = 8'h28;
    localparam logic [7:0] REG_DVS = 8'h2c;
    // widths and field positions
    localparam int NREG = 5;
    localparam int NORM_W = 6;
    localparam int CODE_W = 5;
    localparam int V_W = 16;
    localparam int CNT_W = 12;
    localparam int B4_HI_LSB = 5;
    localparam int SPEED2_LSB = 2;
    localparam int CUR2_LSB = 8;
    localparam int BUSY_LSB = 16;
    // reset values
    localparam logic [5:0] NORM_RST = 6'h20;
    localparam logic [5:0] STBY_RST = 6'h10;
    localparam logic [1:0] SPEED_RST = 2'h1;
    localparam logic [4:0] CODE_RST = 5'h00;
    localparam logic [4:0] MASK_RST = 5'h1f;
    // output voltages in 100 uV units
    localparam logic [15:0] V_FINE_BASE = 16'h1964;
    localparam logic [15:0] V_FINE_STEP = 16'h007d;
    localparam logic [15:0] V_COARSE_STEP = 16'h00fa;
    localparam logic [15:0] V_LOWR_BASE = 16'h2ee0;
    localparam logic [15:0] V_2V5 = 16'h61a8;
    localparam logic [15:0] V_3V15 = 16'h7b0c;
    localparam logic [15:0] V_3V3 = 16'h80e8;
    // high-range select codes
    localparam logic [1:0] HI_LOW = 2'h0;
    localparam logic [1:0] HI_2V5 = 2'h1;
    localparam logic [1:0] HI_3V15 = 2'h2;
    // level-detector codes of the phase-configuration pin
    localparam logic [1:0] PIN_VDIG = 2'h1;
    localparam logic [1:0] PIN_CORE_SUPPLY = 2'h2;
    // voltage stepping: base period and clock rate
    localparam int DVS_BASE_NS = 2000;
    localparam int CLK_MHZ = 250;
    localparam int DVS_BASE_CYC = (DVS_BASE_NS * CLK_MHZ) / 1000;
    typedef enum logic [1:0] {PH_SEPARATE = 2'h0, PH_SINGLE = 2'h1, PH_DUAL = 2'h2} bsc_phase_e;
    typedef enum logic [1:0] {ST_BOOT = 2'h0, ST_SYNC = 2'h1, ST_SAMPLE = 2'h3,
                              ST_RUN = 2'h2} bsc_boot_e;
endpackage : bsc_pkg

// *** verilog/bsc_top.sv ***
// buck set-point decode, phase strap capture, fault flags and voltage stepping
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - an over-current on any buck sets its own fault flag and raises the interrupt unless its mask bit is clear.
// - the third buck maps its 5-bit code from 0.65 V in 25 mV steps up to 1.425 V.
// - the phase-configuration pin is sampled once after reset and then held.
// - ground gives separate outputs, digital core supply single phase, core supply dual.
// - the fourth buck high-range field picks low code, 2.5 V, 3.15 V or 3.3 V.
// - leaving the high range for the low range drives the fourth buck to 2.5 V.
// - starting in the low range, the fourth buck follows its rewritable low code.
// - the fourth buck low code maps from 1.2 V in 25 mV steps to 1.85 V at 11010.
// - the fifth buck code maps from 1.2 V in 25 mV steps to 1.85 V at 11010.
// - the first two bucks hold a normal and a standby code chosen by standby.
// - a write to a normal code steps toward the new value at the scaling rate.
// - standby entry and exit step at the rate of the 2-bit speed field.
// - speed codes give one 12.5 mV step per 2, 4, 8 or 16 us, default 4 us.
module bsc_top #(
    parameter int DVS_BASE_CYC_P = bsc_pkg::DVS_BASE_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [bsc_pkg::NREG-1:0] overcurrentPin,
    input wire logic standbyPin,
    input wire logic [1:0] buck4PhaseConfigPin,
    input wire logic [1:0] powerUpModeSelectPin,
    output logic [bsc_pkg::V_W-1:0] buck1Voltage,
    output logic [bsc_pkg::V_W-1:0] buck2Voltage,
    output logic [bsc_pkg::V_W-1:0] buck3Voltage,
    output logic [bsc_pkg::V_W-1:0] buck4Voltage,
    output logic [bsc_pkg::V_W-1:0] buck5Voltage,
    output logic [1:0] buck4PhaseMode,
    output logic shortCircuitProtectInterrupt
);
    import bsc_pkg::*;

    typedef struct packed {
        logic [NREG-1:0] ocS1;
        logic [NREG-1:0] ocS2;
        logic stbyS1;
        logic stbyS2;
        logic [1:0] phS1;
        logic [1:0] phS2;
        logic [1:0] pumsS1;
        logic [1:0] pumsS2;
        bsc_boot_e boot;
        bsc_phase_e phaseMode;
        logic [1:0][NORM_W-1:0] norm;
        logic [1:0][NORM_W-1:0] stby;
        logic [1:0][1:0] speed;
        logic [CODE_W-1:0] b3Code;
        logic [CODE_W-1:0] b4Low;
        logic [1:0] b4Hi;
        logic b4Forced;
        logic [CODE_W-1:0] b5Code;
        logic [NREG-1:0] status;
        logic [NREG-1:0] mask;
        logic irq;
        logic [31:0] rdata;
        logic [NREG-1:0][V_W-1:0] volt;
    } bsc_state_s;

    bsc_state_s q;
    bsc_state_s d;
    logic [1:0][NORM_W-1:0] dvsCur;
    logic [1:0] dvsBusy;
    logic [NREG-1:0] ocHeld;

    bsc_dvs_if dvsIf[2] ();

    ////////////////////////////////////////////////////////////////////////////////
    // one stepper per standby-capable buck; standby picks which code it chases
    for (genvar i = 0; i < 2; i++)
    begin : g_dvs
        assign dvsIf[i].ce = clkEn;
        assign dvsIf[i].target = q.stbyS2 ? q.stby[i] : q.norm[i];
        assign dvsIf[i].speed = q.speed[i];
        assign dvsCur[i] = dvsIf[i].current;
        assign dvsBusy[i] = dvsIf[i].busy;
        bsc_dvs_stepper #(.BASE_CYC(DVS_BASE_CYC_P)) u_step (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .dvs(dvsIf[i].step)
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        d = q;
        // pins come from outside the clock domain: two flops each
        d.ocS1 = overcurrentPin;
        d.ocS2 = q.ocS1;
        d.stbyS1 = standbyPin;
        d.stbyS2 = q.stbyS1;
        d.phS1 = buck4PhaseConfigPin;
        d.phS2 = q.phS1;
        d.pumsS1 = powerUpModeSelectPin;
        d.pumsS2 = q.pumsS1;

        // startup: wait for the synchronisers to fill, then capture straps once
        unique case (q.boot)
            ST_BOOT: d.boot = ST_SYNC;
            ST_SYNC: d.boot = ST_SAMPLE;
            ST_SAMPLE:
            begin
                d.boot = ST_RUN;
                d.phaseMode = (q.phS2 == PIN_CORE_SUPPLY) ? PH_DUAL :
                              (q.phS2 == PIN_VDIG) ? PH_SINGLE : PH_SEPARATE;
                d.b4Hi = q.pumsS2;
            end
            ST_RUN: d.boot = ST_RUN;
        endcase

        // register writes
        if (regWr)
        begin
            case (regAddr)
                REG_B1_NORM: d.norm[0] = regWdata[NORM_W-1:0];
                REG_B1_STBY: d.stby[0] = regWdata[NORM_W-1:0];
                REG_B2_NORM: d.norm[1] = regWdata[NORM_W-1:0];
                REG_B2_STBY: d.stby[1] = regWdata[NORM_W-1:0];
                REG_SPEED:
                begin
                    d.speed[0] = regWdata[1:0];
                    d.speed[1] = regWdata[SPEED2_LSB+1:SPEED2_LSB];
                end
                REG_B3: d.b3Code = regWdata[CODE_W-1:0];
                REG_B4:
                begin
                    d.b4Low = regWdata[CODE_W-1:0];
                    d.b4Hi = regWdata[B4_HI_LSB+1:B4_HI_LSB];
                    // dropping out of the high range parks the output at 2.5 V
                    d.b4Forced = (d.b4Hi == HI_LOW) && (q.b4Hi != HI_LOW);
                end
                REG_B5: d.b5Code = regWdata[CODE_W-1:0];
                REG_STATUS: d.status = q.status & ~regWdata[NREG-1:0];
                REG_MASK: d.mask = regWdata[NREG-1:0];
                default: d.rdata = q.rdata;
            endcase
        end

        // a live fault beats a write-one clear in the same cycle
        d.status = d.status | q.ocS2;
        d.irq = |(d.status & q.mask);

        // read data stand only in the cycle after the strobe
        d.rdata = '0;
        if (regRd)
        begin
            case (regAddr)
                REG_B1_NORM: d.rdata[NORM_W-1:0] = q.norm[0];
                REG_B1_STBY: d.rdata[NORM_W-1:0] = q.stby[0];
                REG_B2_NORM: d.rdata[NORM_W-1:0] = q.norm[1];
                REG_B2_STBY: d.rdata[NORM_W-1:0] = q.stby[1];
                REG_SPEED: d.rdata[3:0] = q.speed;
                REG_B3: d.rdata[CODE_W-1:0] = q.b3Code;
                REG_B4: d.rdata[B4_HI_LSB+1:0] = {q.b4Hi, q.b4Low};
                REG_B5: d.rdata[CODE_W-1:0] = q.b5Code;
                REG_STATUS: d.rdata[NREG-1:0] = q.status;
                REG_MASK: d.rdata[NREG-1:0] = q.mask;
                REG_CFG: d.rdata[2:0] = {q.b4Forced, q.phaseMode};
                REG_DVS:
                begin
                    d.rdata[NORM_W-1:0] = dvsCur[0];
                    d.rdata[CUR2_LSB+NORM_W-1:CUR2_LSB] = dvsCur[1];
                    d.rdata[BUSY_LSB+1:BUSY_LSB] = dvsBusy;
                end
                default: d.rdata = '0;
            endcase
        end

        // set-point decode; fine bucks follow the stepper, not the register
        for (int i = 0; i < 2; i++)
            d.volt[i] = V_FINE_BASE + V_W'(V_FINE_STEP * dvsCur[i]);
        d.volt[2] = V_FINE_BASE + V_W'(V_COARSE_STEP * q.b3Code);
        unique case (q.b4Hi)
            HI_LOW: d.volt[3] = q.b4Forced ? V_2V5 :
                                V_LOWR_BASE + V_W'(V_COARSE_STEP * q.b4Low);
            HI_2V5: d.volt[3] = V_2V5;
            HI_3V15: d.volt[3] = V_3V15;
            default: d.volt[3] = V_3V3;
        endcase
        // codes above 11010 are undefined; they just extend the line
        d.volt[4] = V_LOWR_BASE + V_W'(V_COARSE_STEP * q.b5Code);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register; clock enable low freezes everything
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            q <= '0;
            q.norm <= {NORM_RST, NORM_RST};
            q.stby <= {STBY_RST, STBY_RST};
            q.speed <= {SPEED_RST, SPEED_RST};
            q.mask <= MASK_RST;
            q.volt[0] <= V_FINE_BASE;
            q.volt[1] <= V_FINE_BASE;
            q.volt[2] <= V_FINE_BASE;
            q.volt[3] <= V_LOWR_BASE;
            q.volt[4] <= V_LOWR_BASE;
        end
        else if (clkEn)
            q <= d;
    end

    assign regRdata = q.rdata;
    assign buck1Voltage = q.volt[0];
    assign buck2Voltage = q.volt[1];
    assign buck3Voltage = q.volt[2];
    assign buck4Voltage = q.volt[3];
    assign buck5Voltage = q.volt[4];
    assign buck4PhaseMode = q.phaseMode;
    assign shortCircuitProtectInterrupt = q.irq;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    assign ocHeld = q.ocS2 & regWdata[NREG-1:0];

    sequence seqHighToLow;
        clkEn && regWr && regAddr == REG_B4 &&
        regWdata[B4_HI_LSB+1:B4_HI_LSB] == HI_LOW && q.b4Hi != HI_LOW;
    endsequence
    sequence seqSample;
        clkEn && q.boot == ST_SAMPLE;
    endsequence

    chk_fault_flag_set: assert property (
        clkEn && |q.ocS2 |=> (q.status & $past(q.ocS2)) == $past(q.ocS2))
        else $error("fault flag not set by over-current");
    chk_irq_raise: assert property (
        clkEn && |(q.ocS2 & q.mask) |=> shortCircuitProtectInterrupt)
        else $error("interrupt not raised for unmasked fault");
    chk_fault_persist: assert property (
        clkEn && regWr && regAddr == REG_STATUS && |ocHeld
        |=> (q.status & $past(ocHeld)) == $past(ocHeld))
        else $error("live fault flag lost to a clear");
    chk_buck3_map: assert property (
        clkEn |=> buck3Voltage == V_FINE_BASE + V_W'(V_COARSE_STEP * $past(q.b3Code)))
        else $error("third buck decode wrong");
    chk_config_frozen: assert property (
        clkEn && q.boot == ST_RUN |=> $stable(buck4PhaseMode) [*2])
        else $error("phase arrangement changed after startup");
    chk_phase_map: assert property (
        seqSample |=> buck4PhaseMode == (($past(q.phS2) == PIN_CORE_SUPPLY) ? PH_DUAL :
                      ($past(q.phS2) == PIN_VDIG) ? PH_SINGLE : PH_SEPARATE))
        else $error("phase arrangement decoded wrong");
    chk_buck4_high: assert property (
        clkEn && q.b4Hi == HI_3V15 |=> buck4Voltage == V_3V15)
        else $error("fourth buck high range wrong");
    chk_buck4_drop: assert property (
        seqHighToLow ##1 clkEn |=> buck4Voltage == V_2V5)
        else $error("fourth buck did not park at 2.5 V");
    chk_buck4_low: assert property (
        clkEn && q.b4Hi == HI_LOW && !q.b4Forced
        |=> buck4Voltage == V_LOWR_BASE + V_W'(V_COARSE_STEP * $past(q.b4Low)))
        else $error("fourth buck low range decode wrong");
    chk_buck5_map: assert property (
        clkEn |=> buck5Voltage == V_LOWR_BASE + V_W'(V_COARSE_STEP * $past(q.b5Code)))
        else $error("fifth buck decode wrong");

    // clears, masking, the fixed high range and set-point selection
    sequence seqStatusClear;
        clkEn && regWr && regAddr == REG_STATUS && !(|ocHeld);
    endsequence
    chk_status_clear: assert property (
        seqStatusClear |=> (q.status & $past(regWdata[NREG-1:0])) == '0)
        else $error("status flag not cleared by a write of one");
    chk_irq_masked: assert property (
        clkEn && !(|((q.status | q.ocS2) & q.mask)) |=> !shortCircuitProtectInterrupt)
        else $error("interrupt raised with no unmasked fault");
    chk_buck4_mid: assert property (
        clkEn && q.b4Hi == HI_2V5 |=> buck4Voltage == V_2V5)
        else $error("fourth buck 2.5 V range wrong");
    chk_buck4_top: assert property (
        clkEn && (&q.b4Hi) |=> buck4Voltage == V_3V3)
        else $error("fourth buck 3.3 V range wrong");
    // the outputs hold their reset value for one edge after release, so wait for run
    chk_standby_select: assert property (
        clkEn && q.boot == ST_RUN && q.stbyS2 && !dvsBusy[0]
        |=> buck1Voltage == V_FINE_BASE + V_W'(V_FINE_STEP * $past(q.stby[0])))
        else $error("first buck not at its standby code");
    chk_normal_select: assert property (
        clkEn && q.boot == ST_RUN && !q.stbyS2 && !dvsBusy[0]
        |=> buck1Voltage == V_FINE_BASE + V_W'(V_FINE_STEP * $past(q.norm[0])))
        else $error("first buck not at its normal code");
    chk_buck2_standby: assert property (
        clkEn && q.boot == ST_RUN && q.stbyS2 && !dvsBusy[1]
        |=> buck2Voltage == V_FINE_BASE + V_W'(V_FINE_STEP * $past(q.stby[1])))
        else $error("second buck not at its standby code");
    chk_buck2_normal: assert property (
        clkEn && q.boot == ST_RUN && !q.stbyS2 && !dvsBusy[1]
        |=> buck2Voltage == V_FINE_BASE + V_W'(V_FINE_STEP * $past(q.norm[1])))
        else $error("second buck not at its normal code");
endmodule : bsc_top
`default_nettype wire
